// ---- include/pspf_pkg.sv ----
// package for the three-port pin logic: register map, field layout, carriers
package pspf_pkg;

  localparam int PSPF_SIX_W  = 4;
  localparam int PSPF_TWO_W  = 7;
  localparam int PSPF_FIVE_W = 2;
  localparam int PSPF_ADDR_W = 4;

  // register offsets
  localparam logic [3:0] PSPF_SIX_OUT_OFF  = 4'h0;
  localparam logic [3:0] PSPF_SIX_DIR_OFF  = 4'h1;
  localparam logic [3:0] PSPF_SIX_OD_OFF   = 4'h2;
  localparam logic [3:0] PSPF_SIX_ALT_OFF  = 4'h3;
  localparam logic [3:0] PSPF_SIX_IN_OFF   = 4'h4;
  localparam logic [3:0] PSPF_TWO_OUT_OFF  = 4'h5;
  localparam logic [3:0] PSPF_TWO_DIR_OFF  = 4'h6;
  localparam logic [3:0] PSPF_TWO_OD_OFF   = 4'h7;
  localparam logic [3:0] PSPF_TWO_IN_OFF   = 4'h8;
  localparam logic [3:0] PSPF_FIVE_IN_OFF  = 4'h9;

  // field positions inside the two-pin input port
  localparam int PSPF_FIVE_T4_BIT = 0;
  localparam int PSPF_FIVE_T5_BIT = 1;
  // lowest port_two bit number routed to the fast interrupt inputs
  localparam int PSPF_TWO_FIRST_BIT = 9;

  // reset values: every pin input, push/pull, port latch low, alternate off
  localparam logic [3:0] PSPF_SIX_OUT_RST = 4'h0;
  localparam logic [3:0] PSPF_SIX_DIR_RST = 4'h0;
  localparam logic [3:0] PSPF_SIX_OD_RST  = 4'h0;
  localparam logic [3:0] PSPF_SIX_ALT_RST = 4'h0;
  localparam logic [6:0] PSPF_TWO_OUT_RST = 7'h00;
  localparam logic [6:0] PSPF_TWO_DIR_RST = 7'h00;
  localparam logic [6:0] PSPF_TWO_OD_RST  = 7'h00;

  typedef struct packed {
    logic [PSPF_ADDR_W-1:0] addr;
    logic [15:0]            wdata;
    logic                   wr;
    logic                   rd;
  } pspf_bus_req_t;

  typedef struct packed {
    logic up_down_t4;
    logic up_down_t5;
  } pspf_timer_dir_t;

endpackage : pspf_pkg

// ---- src/pspf_pin_cell.sv ----
`timescale 1ns/1ps
// one port's worth of pin drivers: sync input, direction, push/pull or open drain
module pspf_pin_cell
  import pspf_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,      // cpu clock
  input  wire logic             sys_rst,  // synchronous reset, high
  input  wire logic [WIDTH-1:0] pin_i,    // pad level seen
  input  wire logic [WIDTH-1:0] level,    // level to drive
  input  wire logic [WIDTH-1:0] dir_out,  // 1 = output
  input  wire logic [WIDTH-1:0] od_mode,  // 1 = open drain
  output logic      [WIDTH-1:0] pin_o,    // pad output value
  output logic      [WIDTH-1:0] pin_oe_n, // pad enable, low drives
  output logic      [WIDTH-1:0] sync_o    // two-stage synchronised level
);

  logic [WIDTH-1:0] meta_reg;

  // refused at elaboration: the read mux packs a port into 16 bits
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("pspf_pin_cell: width out of range");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_o[g]    <= 1'b0;
          pin_oe_n[g] <= 1'b1;
        end else begin
          // open drain only pulls low; a high releases the pad
          pin_o[g]    <= od_mode[g] ? 1'b0 : level[g];
          pin_oe_n[g] <= !dir_out[g] || (od_mode[g] && level[g]);
        end
      end
    end
  endgenerate

endmodule : pspf_pin_cell

// ---- src/pspf_ports.sv ----
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// pin logic of port_six, port_two and port_five with register port and alternates
//
// Contract
// - port_six has four pins, each with its own direction bit.
// - a pin set as input on port_two, or on port_six with its alternate bit off, has its driver off.
// - port_six drivers can be set to push/pull or open drain.
// - port_two has seven pins, each with its own direction control.
// - port_two drivers can be set to push/pull or open drain.
// - port_six bits 0 to 3 carry chip_select_out 0 to 3 in order.
// - port_two bits 9 to 15 feed fast_ext_irq_in 1 to 7 in order.
// - port_five is two input-only pins whose levels software can read.
// - port_five bit 14 is timer four up/down, bit 15 timer five up/down.
module pspf_ports
  import pspf_pkg::*;
(
  input  wire logic                   clk,               // cpu clock, 10 MHz
  input  wire logic                   sys_rst,           // synchronous reset, high
  input  wire pspf_bus_req_t          bus_req,           // register access request
  output logic [15:0]                 rdata,             // read data, cycle after strobe
  input  wire logic [PSPF_SIX_W-1:0]  chip_select_out,   // chip selects from bus controller
  input  wire logic [PSPF_SIX_W-1:0]  port_six_i,        // port_six pad level
  output logic      [PSPF_SIX_W-1:0]  port_six_o,        // port_six pad value
  output logic      [PSPF_SIX_W-1:0]  port_six_oe_n,     // port_six enable, low drives
  input  wire logic [PSPF_TWO_W-1:0]  port_two_i,        // port_two pad level, bits 9..15
  output logic      [PSPF_TWO_W-1:0]  port_two_o,        // port_two pad value
  output logic      [PSPF_TWO_W-1:0]  port_two_oe_n,     // port_two enable, low drives
  output logic      [PSPF_TWO_W-1:0]  fast_ext_irq_in,   // sync levels to fast interrupts 1..7
  input  wire logic [PSPF_FIVE_W-1:0] port_five_i,       // port_five pads, bits 14..15
  output pspf_timer_dir_t             timer_dir          // up/down inputs of timers four, five
);

  logic [3:0] six_out_reg;
  logic [3:0] six_dir_reg;
  logic [3:0] six_od_reg;
  logic [3:0] six_alt_reg;
  logic [6:0] two_out_reg;
  logic [6:0] two_dir_reg;
  logic [6:0] two_od_reg;
  logic [3:0] six_level;
  logic [3:0] six_dir_eff;
  logic [3:0] six_sync;
  logic [6:0] two_sync;
  logic [1:0] five_meta_reg;
  logic [1:0] five_sync_reg;
  logic [15:0] rdata_next;

  function automatic logic hit(input pspf_bus_req_t r, input logic [3:0] off);
    return r.wr && (r.addr == off);
  endfunction : hit

  // register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      six_dir_reg <= PSPF_SIX_DIR_RST;
      two_dir_reg <= PSPF_TWO_DIR_RST;
    end else begin
      if (hit(bus_req, PSPF_SIX_DIR_OFF)) six_dir_reg <= bus_req.wdata[3:0];
      if (hit(bus_req, PSPF_TWO_DIR_OFF)) two_dir_reg <= bus_req.wdata[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      six_out_reg <= PSPF_SIX_OUT_RST;
      six_od_reg  <= PSPF_SIX_OD_RST;
      six_alt_reg <= PSPF_SIX_ALT_RST;
      two_out_reg <= PSPF_TWO_OUT_RST;
      two_od_reg  <= PSPF_TWO_OD_RST;
    end else begin
      if (hit(bus_req, PSPF_SIX_OUT_OFF)) six_out_reg <= bus_req.wdata[3:0];
      if (hit(bus_req, PSPF_SIX_OD_OFF))  six_od_reg  <= bus_req.wdata[3:0];
      if (hit(bus_req, PSPF_SIX_ALT_OFF)) six_alt_reg <= bus_req.wdata[3:0];
      if (hit(bus_req, PSPF_TWO_OUT_OFF)) two_out_reg <= bus_req.wdata[6:0];
      if (hit(bus_req, PSPF_TWO_OD_OFF))  two_od_reg  <= bus_req.wdata[6:0];
    end
  end

  // an enabled chip select drives its pin whatever the direction bit says
  always_comb begin
    six_level   = (six_alt_reg & chip_select_out) | (~six_alt_reg & six_out_reg);
    six_dir_eff = six_dir_reg | six_alt_reg;
  end

  pspf_pin_cell #(.WIDTH(PSPF_SIX_W)) u_six (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_i    (port_six_i),
    .level    (six_level),
    .dir_out  (six_dir_eff),
    .od_mode  (six_od_reg),
    .pin_o    (port_six_o),
    .pin_oe_n (port_six_oe_n),
    .sync_o   (six_sync)
  );

  pspf_pin_cell #(.WIDTH(PSPF_TWO_W)) u_two (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_i    (port_two_i),
    .level    (two_out_reg),
    .dir_out  (two_dir_reg),
    .od_mode  (two_od_reg),
    .pin_o    (port_two_o),
    .pin_oe_n (port_two_oe_n),
    .sync_o   (two_sync)
  );

  // interrupt inputs see the pad even when the pin drives, as the pad is shared
  always_ff @(posedge clk) begin
    if (sys_rst) fast_ext_irq_in <= '0;
    else fast_ext_irq_in <= two_sync;
  end

  // port_five has no drivers at all, only a synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      five_meta_reg <= '0;
      five_sync_reg <= '0;
      timer_dir     <= '0;
    end else begin
      five_meta_reg        <= port_five_i;
      five_sync_reg        <= five_meta_reg;
      timer_dir.up_down_t4 <= five_sync_reg[PSPF_FIVE_T4_BIT];
      timer_dir.up_down_t5 <= five_sync_reg[PSPF_FIVE_T5_BIT];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_next = 16'h0000;
    case (bus_req.addr)
      PSPF_SIX_OUT_OFF: rdata_next = {12'h000, six_out_reg};
      PSPF_SIX_DIR_OFF: rdata_next = {12'h000, six_dir_reg};
      PSPF_SIX_OD_OFF:  rdata_next = {12'h000, six_od_reg};
      PSPF_SIX_ALT_OFF: rdata_next = {12'h000, six_alt_reg};
      PSPF_SIX_IN_OFF:  rdata_next = {12'h000, six_sync};
      PSPF_TWO_OUT_OFF: rdata_next = {9'h0, two_out_reg};
      PSPF_TWO_DIR_OFF: rdata_next = {9'h0, two_dir_reg};
      PSPF_TWO_OD_OFF:  rdata_next = {9'h0, two_od_reg};
      PSPF_TWO_IN_OFF:  rdata_next = {9'h0, two_sync};
      PSPF_FIVE_IN_OFF: rdata_next = {14'h0, five_sync_reg};
      default:          rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rdata <= 16'h0000;
    else if (bus_req.rd) rdata <= rdata_next;
    else rdata <= 16'h0000;
  end

  // checks
  dir_reset_input_a: assert property (@(posedge clk)
    $past(sys_rst) |-> (six_dir_reg == 4'h0 && two_dir_reg == 7'h00))
    else $error("direction not input after reset");

  six_input_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (six_dir_eff == 4'h0) |=> (port_six_oe_n == 4'hf))
    else $error("port_six drives while input");

  two_input_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (two_dir_reg == 7'h00) |=> (port_two_oe_n == 7'h7f))
    else $error("port_two drives while input");

  six_od_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    (six_od_reg[0] && six_dir_eff[0] && six_level[0]) |=> port_six_oe_n[0])
    else $error("open drain drove high");

  two_od_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (two_od_reg[0] && two_dir_reg[0] && !two_out_reg[0]) |=>
      (!port_two_oe_n[0] && !port_two_o[0]))
    else $error("open drain not pulling low");

  six_dir_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    hit(bus_req, PSPF_SIX_DIR_OFF) |=> six_dir_reg == $past(bus_req.wdata[3:0]))
    else $error("port_six direction write lost");

  two_dir_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    hit(bus_req, PSPF_TWO_DIR_OFF) |=> two_dir_reg == $past(bus_req.wdata[6:0]))
    else $error("port_two direction write lost");

  cs_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    (six_alt_reg[2] && !six_od_reg[2]) |=>
      (port_six_o[2] == $past(chip_select_out[2]) && !port_six_oe_n[2]))
    else $error("chip select not on pin");

  irq_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##3 1'b1 |-> fast_ext_irq_in == $past(port_two_i, 3))
    else $error("fast interrupt path wrong");

  timer_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##3 1'b1 |-> (timer_dir.up_down_t4 == $past(port_five_i[0], 3) &&
                  timer_dir.up_down_t5 == $past(port_five_i[1], 3)))
    else $error("timer direction path wrong");

endmodule : pspf_ports

// ---- test/pspf_board.sv ----
// board model: resolves each pad from the device driver and the external source
`timescale 1ns/1ps
module pspf_board
  import pspf_pkg::*;
(
  input  wire logic [PSPF_SIX_W-1:0] six_o,    // device pad value
  input  wire logic [PSPF_SIX_W-1:0] six_oe_n, // device enable, low drives
  input  wire logic [PSPF_SIX_W-1:0] six_ext,  // external source level
  input  wire logic [PSPF_TWO_W-1:0] two_o,    // device pad value
  input  wire logic [PSPF_TWO_W-1:0] two_oe_n, // device enable, low drives
  input  wire logic [PSPF_TWO_W-1:0] two_ext,  // external source level
  output logic      [PSPF_SIX_W-1:0] six_pad,  // resolved level
  output logic      [PSPF_TWO_W-1:0] two_pad   // resolved level
);
  // a released pad follows the external source, never the device's last value
  always_comb begin
    six_pad = (six_oe_n & six_ext) | (~six_oe_n & six_o);
    two_pad = (two_oe_n & two_ext) | (~two_oe_n & two_o);
  end
endmodule : pspf_board

// ---- test/test_port_six_two_five_pins.sv ----
// self-checking bench of the three-port pin logic
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_port_six_two_five_pins;
  import pspf_pkg::*;
  logic            clk = 1'b0;
  logic            sys_rst = 1'b1;
  pspf_bus_req_t   req = '0;
  logic [15:0]     rdata;
  logic [3:0]      cs = 4'h0, six_pad, six_o, six_oe_n, six_ext = 4'h0;
  logic [6:0]      two_pad, two_o, two_oe_n, two_ext = 7'h00, irq;
  logic [1:0]      five = 2'b00;
  pspf_timer_dir_t tdir;
  int              n_fail = 0;
  int              checks_done = 0;

  pspf_ports dut (.clk(clk), .sys_rst(sys_rst), .bus_req(req), .rdata(rdata),
    .chip_select_out(cs), .port_six_i(six_pad), .port_six_o(six_o),
    .port_six_oe_n(six_oe_n), .port_two_i(two_pad), .port_two_o(two_o),
    .port_two_oe_n(two_oe_n), .fast_ext_irq_in(irq), .port_five_i(five),
    .timer_dir(tdir));
  pspf_board board (.six_o(six_o), .six_oe_n(six_oe_n), .six_ext(six_ext),
    .two_o(two_o), .two_oe_n(two_oe_n), .two_ext(two_ext),
    .six_pad(six_pad), .two_pad(two_pad));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // pins follow one edge after the write; the input paths need three
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  logic [15:0] v;
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    `CHK(six_oe_n, 4'hf)
    `CHK(two_oe_n, 7'h7f)
    rd(PSPF_SIX_DIR_OFF, v); `CHK(v, 16'h0000)
    rd(PSPF_TWO_DIR_OFF, v); `CHK(v, 16'h0000)
    // read data stand one cycle only
    @(posedge clk);
    #1 `CHK(rdata, 16'h0000)
    // mixed directions on port_six, released pins pulled low outside
    wr(PSPF_SIX_OUT_OFF, 16'h000f);
    wr(PSPF_SIX_DIR_OFF, 16'hfff5);
    settle();
    `CHK(six_oe_n, 4'ha)
    `CHK(six_pad, 4'h5)
    rd(PSPF_SIX_DIR_OFF, v); `CHK(v, 16'h0005)
    rd(PSPF_SIX_IN_OFF, v); `CHK(v, 16'h0005)
    wr(PSPF_SIX_OD_OFF, 16'h0001);
    settle();
    `CHK(six_oe_n, 4'hb)
    wr(PSPF_SIX_OUT_OFF, 16'h000e);
    settle();
    `CHK(six_oe_n[0], 1'b0)
    `CHK(six_pad[0], 1'b0)
    // port_two push/pull, then open drain, then back to input
    wr(PSPF_TWO_OUT_OFF, 16'h0055);
    wr(PSPF_TWO_DIR_OFF, 16'h007f);
    settle();
    `CHK(two_oe_n, 7'h00)
    `CHK(two_pad, 7'h55)
    wr(PSPF_TWO_OD_OFF, 16'h007f);
    settle();
    `CHK(two_oe_n, 7'h55)
    `CHK(two_pad[1], 1'b0)
    // a low level on an open-drain pin is still pulled down
    wr(PSPF_TWO_OUT_OFF, 16'h002a);
    settle();
    `CHK(two_oe_n, 7'h2a)
    `CHK(two_pad, 7'h00)
    wr(PSPF_TWO_DIR_OFF, 16'h0000);
    settle();
    `CHK(two_oe_n, 7'h7f)
    // chip selects take over port_six in order
    wr(PSPF_SIX_OD_OFF, 16'h0000);
    wr(PSPF_SIX_ALT_OFF, 16'h000f);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cs <= 4'h1 << i;
      settle();
      `CHK(six_pad, 4'h1 << i)
      `CHK(six_oe_n, 4'h0)
    end
    // each external interrupt pad reaches its own input
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      two_ext <= 7'h01 << i;
      settle();
      `CHK(irq, 7'h01 << i)
    end
    rd(PSPF_TWO_IN_OFF, v); `CHK(v, 16'h0040)
    // timer direction inputs, read-only port and an unmapped address
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      five <= i[1:0];
      settle();
      `CHK(tdir.up_down_t4, i[0])
      `CHK(tdir.up_down_t5, i[1])
      rd(PSPF_FIVE_IN_OFF, v); `CHK(v, 16'(i))
    end
    wr(PSPF_FIVE_IN_OFF, 16'h0000);
    rd(PSPF_FIVE_IN_OFF, v); `CHK(v, 16'h0003)
    wr(4'hf, 16'hffff);
    rd(4'hf, v); `CHK(v, 16'h0000)
    complete_run();
  end

  // a hang is cut short and counted
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : test_port_six_two_five_pins
